// ===== shared/bcg_pkg.sv
// bcg_pkg: opcodes, queue geometry and field widths of the bus cycle generator
// assumes a single core_clk domain; shared by the design and its bench
package bcg_pkg;
  localparam int QUEUE_DEPTH = 16;
  localparam int QPTR_W = 4;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int IDLE_W = 8;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] PAGE_RESET = 32'h0000_0000;
  localparam logic [3:0] MASK_RESET = 4'hF;
  localparam logic [1:0] SIZE_RESET = 2'h2;
  localparam logic [7:0] IDLE_ONE = 8'h01;

  typedef enum logic [3:0]
  {
    BCG_CMD_NONE = 4'h0,
    BCG_CMD_SET_ADDR = 4'h1,
    BCG_CMD_SET_PAGE = 4'h2,
    BCG_CMD_SET_SIZE = 4'h3,
    BCG_CMD_SET_BYTES = 4'h4,
    BCG_CMD_RD = 4'h5,
    BCG_CMD_CRD = 4'h6,
    BCG_CMD_WR = 4'h7,
    BCG_CMD_FWR = 4'h8,
    BCG_CMD_IDLE = 4'h9,
    BCG_CMD_SWAP = 4'hA
  } bcg_cmd_t;

  typedef enum logic [1:0]
  {
    BCG_OP_IDLE = 2'h0,
    BCG_OP_RD = 2'h1,
    BCG_OP_WR = 2'h2
  } bcg_op_t;

  typedef struct packed
  {
    bcg_op_t op;
    logic clf;
    logic lock;
    logic [31:0] addr;
    logic [3:0] lanes;
    logic [31:0] data;
    logic [31:0] care;
  } bcg_entry_t;
endpackage

// ===== verilog/bcg_bus_transactor.sv
// bcg_bus_transactor: command driven bus master with a circular queue that takes one or two entries per cycle
// assumes commands, wait and read data are synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module bcg_bus_transactor
  import bcg_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic enhanced_mode,
  input wire logic cmd_valid,
  input wire bcg_pkg::bcg_cmd_t cmd_code,
  input wire logic [31:0] cmd_arg,
  input wire logic [31:0] cmd_arg2,
  input wire logic [31:0] cmd_care,
  output logic cmd_ready,
  output logic [31:0] bus_addr,
  output logic [1:0] bus_size,
  output logic bus_req,
  output logic bus_write,
  output logic bus_seq,
  output logic bus_clf,
  output logic bus_lock,
  output logic [31:0] bus_wdata,
  output logic bus_wdata_oe,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_wait,
  output logic read_error,
  output logic merge_error
);
  import bcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed
  {
    logic [31:0] base;
    logic [31:0] page;
    logic [3:0] lanes;
    logic [QPTR_W-1:0] wr_ptr;
    logic [QPTR_W-1:0] rd_ptr;
    logic [QPTR_W:0] count;
    bcg_op_t last_op;
    logic [IDLE_W-1:0] idle_left;
    logic active;
    bcg_entry_t cur;
    logic seq;
    logic read_error;
    logic merge_error;
  } bcg_state_t;

  bcg_state_t st;
  bcg_state_t next_st;
  bcg_entry_t queue [QUEUE_DEPTH];
  bcg_entry_t push_a;
  bcg_entry_t push_b;
  logic [1:0] push_n;
  logic pop;
  logic is_op;
  logic full;
  logic rd_mismatch;

  assign full = (st.count > 5'(QUEUE_DEPTH - 2));
  assign is_op = (cmd_code == BCG_CMD_RD) || (cmd_code == BCG_CMD_CRD)
    || (cmd_code == BCG_CMD_WR) || (cmd_code == BCG_CMD_FWR)
    || (cmd_code == BCG_CMD_IDLE) || (cmd_code == BCG_CMD_SWAP);
  assign cmd_ready = !full;
  // cycle ends when wait is low; a popped entry is consumed then
  assign pop = (!st.active || !bus_wait) && (st.idle_left == 8'h00);
  assign rd_mismatch = ((bus_rdata ^ st.cur.data) & st.cur.care) != 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // command decode and queue/bus sequencing
  always_comb
  begin
    next_st = st;
    push_a = '0;
    push_b = '0;
    push_n = 2'h0;
    push_a.addr = st.base | st.page;
    push_a.lanes = st.lanes;
    push_a.data = cmd_arg;
    push_a.care = cmd_care;
    push_b = push_a;
    if (cmd_valid)
    begin
      unique case (cmd_code)
        BCG_CMD_SET_ADDR: next_st.base = cmd_arg;
        BCG_CMD_SET_PAGE: next_st.page = cmd_arg;
        BCG_CMD_SET_SIZE: next_st.lanes = {2'h0, cmd_arg[1:0]};
        BCG_CMD_SET_BYTES: next_st.lanes = cmd_arg[3:0];
        default: ;
      endcase
    end
    if (cmd_valid && is_op && !full)
    begin
      unique case (cmd_code)
        BCG_CMD_RD, BCG_CMD_CRD:
        begin
          push_a.op = BCG_OP_RD;
          push_a.clf = (cmd_code == BCG_CMD_CRD);
          push_n = 2'h1;
        end
        BCG_CMD_WR, BCG_CMD_FWR:
        begin
          push_a.op = BCG_OP_WR;
          push_a.clf = (cmd_code == BCG_CMD_FWR);
          push_a.care = 32'hFFFF_FFFF;
          push_n = 2'h1;
        end
        BCG_CMD_IDLE:
        begin
          push_a.op = BCG_OP_IDLE;
          push_a.data = {24'h0, cmd_arg[7:0]};
          push_n = (cmd_arg[7:0] == 8'h00) ? 2'h0 : 2'h1;
        end
        BCG_CMD_SWAP:
        begin
          push_a.op = BCG_OP_RD;
          push_a.lock = 1'b1;
          push_b.op = BCG_OP_WR;
          push_b.lock = 1'b1;
          push_b.data = cmd_arg2;
          push_b.care = 32'hFFFF_FFFF;
          push_n = 2'h2;
        end
        default: ;
      endcase
    end
    if (push_n != 2'h0)
    begin
      next_st.wr_ptr = st.wr_ptr + QPTR_W'(push_n);
      next_st.last_op = (push_n == 2'h2) ? BCG_OP_WR : push_a.op;
    end
    // completion of current cycle
    if (st.active && !bus_wait && st.cur.op == BCG_OP_RD && rd_mismatch)
      next_st.read_error = 1'b1;
    if (st.idle_left != 8'h00)
      next_st.idle_left = st.idle_left - 8'h01;
    if (pop)
    begin
      next_st.active = 1'b0;
      if (st.count != 5'h0)
      begin
        next_st.rd_ptr = st.rd_ptr + 4'h1;
        next_st.cur = queue[st.rd_ptr];
        if (queue[st.rd_ptr].op == BCG_OP_IDLE)
        begin
          next_st.idle_left = queue[st.rd_ptr].data[7:0] - IDLE_ONE;
          next_st.seq = 1'b0;
        end
        else if (st.active && st.cur.op != queue[st.rd_ptr].op && !st.cur.lock)
        begin
          // direction flip inside a burst: stall one idle cycle, retry later
          next_st.rd_ptr = st.rd_ptr;
          next_st.cur.op = BCG_OP_IDLE;
          next_st.seq = 1'b0;
          next_st.merge_error = 1'b1;
        end
        else
        begin
          next_st.active = 1'b1;
          // no address or line-fill check on sequential beats
          next_st.seq = st.active && (st.cur.op == queue[st.rd_ptr].op);
        end
      end
      else
      begin
        next_st.cur.op = BCG_OP_IDLE;
        next_st.seq = 1'b0;
      end
    end
    next_st.count = st.count + 5'(push_n) - ((pop && next_st.rd_ptr != st.rd_ptr) ? 5'h1 : 5'h0);
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
      st.base <= ADDR_RESET;
      st.page <= PAGE_RESET;
      st.lanes <= MASK_RESET;
    end
    else
      st <= next_st;
  end

  // queue storage, written one or two entries per push
  always_ff @(posedge core_clk)
  begin
    if (push_n != 2'h0)
      queue[st.wr_ptr] <= push_a;
    if (push_n == 2'h2)
      queue[st.wr_ptr + 4'h1] <= push_b;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus outputs
  always_comb
  begin
    bus_req = st.active;
    bus_write = st.active && (st.cur.op == BCG_OP_WR);
    bus_seq = st.active && st.seq;
    bus_clf = st.active && st.cur.clf;
    bus_lock = st.active && st.cur.lock;
    bus_wdata = st.cur.data;
    bus_wdata_oe = bus_write;
    if (enhanced_mode)
    begin
      bus_addr = {st.cur.addr[31:2], st.cur.lanes[1:0]};
      bus_size = st.cur.lanes[3:2];
    end
    else
    begin
      bus_addr = st.cur.addr;
      bus_size = st.cur.lanes[1:0];
    end
    read_error = st.read_error;
    merge_error = st.merge_error;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_full_refuse: assert property (@(posedge core_clk) disable iff (!reset_n)
    full |-> !cmd_ready) else $error("ready high while queue full");
  chk_addr_or: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cmd_valid && cmd_code == BCG_CMD_RD && !full && st.count == 5'h0 && !st.active
    && st.idle_left == 8'h00)
    |-> ##2 bus_req && bus_addr[31:2] == $past(st.base[31:2] | st.page[31:2], 2))
    else $error("read address not base or page");
  chk_wait_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    (bus_req && bus_wait) |=> bus_req && $stable(bus_addr))
    else $error("cycle not stretched by wait");
  chk_read_check: assert property (@(posedge core_clk) disable iff (!reset_n)
    (bus_req && !bus_write && !bus_wait && rd_mismatch) |=> read_error)
    else $error("mismatch not flagged");
  chk_wr_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
    bus_write |-> bus_wdata_oe && bus_wdata == st.cur.data) else $error("write data");
  chk_idle_empty: assert property (@(posedge core_clk) disable iff (!reset_n)
    (st.count == 5'h0 && !bus_wait) |=> !bus_req) else $error("bus busy with empty queue");
  chk_set_nopush: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cmd_valid && cmd_code == BCG_CMD_SET_ADDR) |=> st.wr_ptr == $past(st.wr_ptr))
    else $error("setting command pushed");
  chk_idle_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cmd_valid && cmd_code == BCG_CMD_IDLE && cmd_arg[7:0] == 8'h00)
    |=> st.wr_ptr == $past(st.wr_ptr)) else $error("zero idle pushed");
  // an unlocked beat that ends, then a sequential beat in the next cycle
  sequence s_beat_end;
    bus_req && !bus_wait && !bus_lock;
  endsequence
  sequence s_seq_beat;
    bus_req && bus_seq;
  endsequence
  chk_no_flip: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_beat_end ##1 s_seq_beat |-> $stable(bus_write))
    else $error("direction flip merged");
endmodule // bcg_bus_transactor
`default_nettype wire

// ===== verification/bcg_mem_model.sv
// bcg_mem_model: far-side memory, answers reads and stretches cycles
// assumes registered bus outputs on core_clk
`timescale 1ns/1ps
`default_nettype none
module bcg_mem_model
#(
  parameter logic [31:0] KEY = 32'h5A3C_0FF0
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic stall_en,
  input wire logic [31:0] bus_addr,
  input wire logic bus_req,
  input wire logic bus_write,
  output logic [31:0] bus_rdata,
  output logic bus_wait
);
  logic [31:0] last;
  // outside read cycles the data lines keep changing
  assign bus_rdata = (bus_req && !bus_write) ? (bus_addr ^ KEY) : ~last;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      last <= 32'h0;
      bus_wait <= 1'b0;
    end
    else
    begin
      last <= bus_rdata;
      bus_wait <= stall_en && bus_req && !bus_wait && ($urandom_range(0, 1) == 1);
    end
  end
endmodule // bcg_mem_model
`default_nettype wire

// ===== verification/bcg_bus_transactor_tb.sv
// bcg_bus_transactor_tb: queue model of expected bus cycles, compared at each beat that ends with wait low
// assumes bcg_pkg and bcg_mem_model
`timescale 1ns/1ps
`default_nettype none
module bcg_bus_transactor_tb;
  import bcg_pkg::*;
  localparam logic [31:0] KEY = 32'h5A3C_0FF0;
  logic core_clk = 1'b0, reset_n = 1'b0, enhanced_mode = 1'b0, cmd_valid = 1'b0;
  logic stall_en = 1'b0, saw_busy = 1'b0, ms, cont = 1'b0;
  bcg_cmd_t cmd_code = BCG_CMD_NONE;
  logic [31:0] cmd_arg = 32'h0, cmd_arg2 = 32'h0, cmd_care = 32'h0;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, base = ADDR_RESET, page = PAGE_RESET;
  logic [1:0] bus_size, size = SIZE_RESET;
  logic [3:0] mask = MASK_RESET;
  logic cmd_ready, bus_req, bus_write, bus_seq, bus_clf, bus_lock, bus_wdata_oe, bus_wait;
  logic read_error, merge_error;
  int n_mismatch = 0, checks = 0, last_dir = 0;
  bcg_entry_t q[$], me;
  logic sq[$];
  always #25 core_clk = ~core_clk;
  bcg_bus_transactor dut (.core_clk, .reset_n, .enhanced_mode, .cmd_valid, .cmd_code,
    .cmd_arg, .cmd_arg2, .cmd_care, .cmd_ready, .bus_addr, .bus_size, .bus_req, .bus_write,
    .bus_seq, .bus_clf, .bus_lock, .bus_wdata, .bus_wdata_oe, .bus_rdata, .bus_wait,
    .read_error, .merge_error);
  bcg_mem_model #(.KEY(KEY)) mem (.core_clk, .reset_n, .stall_en, .bus_addr, .bus_req,
    .bus_write, .bus_rdata, .bus_wait);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [31:0] addr_now();
    return enhanced_mode ? {base[31:2] | page[31:2], mask[1:0]} : (base | page);
  endfunction
  task automatic push(input bcg_op_t op, input logic clf, input logic lock, input logic [31:0] d);
    bcg_entry_t e;
    e = '0;
    e.op = op;
    e.clf = clf;
    e.lock = lock;
    e.addr = addr_now();
    e.lanes = {2'h0, enhanced_mode ? mask[3:2] : size};
    e.data = d;
    q.push_back(e);
    sq.push_back(!lock && last_dir == int'(op));
    last_dir = int'(op);
  endtask
  task automatic send(input bcg_cmd_t c, input logic [31:0] a, input logic [31:0] a2 = 32'h0,
    input logic [31:0] cr = 32'hFFFF_FFFF);
    int i;
    i = 0;
    while (c >= BCG_CMD_RD && cmd_ready !== 1'b1 && i < 400)
    begin
      saw_busy = 1'b1;
      cmd_valid = 1'b0;
      @(posedge core_clk);
      #2;
      i++;
    end
    if (i == 400)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    cmd_code = c;
    cmd_arg = a;
    cmd_arg2 = a2;
    cmd_care = cr;
    cmd_valid = 1'b1;
    @(posedge core_clk);
    #2;
    case (c)
      BCG_CMD_SET_ADDR: base = a;
      BCG_CMD_SET_PAGE: page = a;
      BCG_CMD_SET_SIZE: size = a[1:0];
      BCG_CMD_SET_BYTES: mask = a[3:0];
      BCG_CMD_RD, BCG_CMD_CRD: push(BCG_OP_RD, c == BCG_CMD_CRD, 1'b0, 32'h0);
      BCG_CMD_WR, BCG_CMD_FWR: push(BCG_OP_WR, c == BCG_CMD_FWR, 1'b0, a);
      BCG_CMD_SWAP:
      begin
        push(BCG_OP_RD, 1'b0, 1'b1, 32'h0);
        push(BCG_OP_WR, 1'b0, 1'b1, a2);
      end
      BCG_CMD_IDLE: if (a[7:0] != 8'h0) last_dir = 0;
      default: ;
    endcase
  endtask
  task automatic drain;
    int i;
    cmd_valid = 1'b0;
    i = 0;
    while ((q.size() != 0 || bus_req !== 1'b0) && i < 1000)
    begin
      @(posedge core_clk);
      #2;
      i++;
    end
    if (i == 1000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk)
    if (reset_n && bus_req === 1'b1 && bus_wait === 1'b0)
    begin
      if (q.size() == 0)
        chk("spare cycle", 32'h0, 32'h1);
      else
      begin
        // a burst only continues if the next entry was already queued when this beat ended
        me = q.pop_front();
        ms = sq.pop_front() && cont;
        cont = (q.size() != 0);
        chk("addr", me.addr, bus_addr);
        chk("size", {30'h0, me.lanes[1:0]}, {30'h0, bus_size});
        chk("kind", {27'h0, me.op == BCG_OP_WR, me.op == BCG_OP_WR, me.clf, me.lock, ms},
          {27'h0, bus_write, bus_wdata_oe, bus_clf, bus_lock, bus_seq && !bus_lock});
        if (me.op == BCG_OP_WR)
          chk("wdata", me.data, bus_wdata);
      end
    end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h75DA5827));
    repeat (12) @(posedge core_clk);
    #2;
    reset_n = 1'b1;
    chk("ready", 32'h1, {31'h0, cmd_ready});
    send(BCG_CMD_SET_ADDR, 32'h0040_0018);
    send(BCG_CMD_SET_PAGE, 32'h0000_0030);
    for (int s = 0; s < 4; s++)
    begin
      send(BCG_CMD_SET_SIZE, 32'(s));
      send(s[0] ? BCG_CMD_FWR : BCG_CMD_WR, $urandom());
    end
    send(BCG_CMD_IDLE, 32'h0);
    send(BCG_CMD_WR, $urandom());
    send(BCG_CMD_IDLE, 32'h1);
    drain();
    chk("merge", 32'h0, {31'h0, merge_error});
    stall_en = 1'b1;
    send(BCG_CMD_SET_PAGE, 32'h0000_0100);
    send(BCG_CMD_RD, addr_now() ^ KEY);
    send(BCG_CMD_CRD, addr_now() ^ KEY);
    send(BCG_CMD_WR, $urandom());
    send(BCG_CMD_IDLE, 32'h2);
    send(BCG_CMD_SWAP, addr_now() ^ KEY, $urandom());
    send(BCG_CMD_IDLE, 32'h1);
    drain();
    chk("merge", 32'h1, {31'h0, merge_error});
    chk("rerr", 32'h0, {31'h0, read_error});
    enhanced_mode = 1'b1;
    send(BCG_CMD_SET_BYTES, 32'hC);
    send(BCG_CMD_RD, addr_now() ^ KEY ^ 32'hFF00_0000, 32'h0, 32'h00FF_FFFF);
    // the bench issues eight CRD commands as an eight beat line fill
    for (int k = 0; k < 8; k++)
      send(BCG_CMD_CRD, addr_now() ^ KEY);
    send(BCG_CMD_IDLE, 32'h1);
    drain();
    chk("rerr", 32'h0, {31'h0, read_error});
    send(BCG_CMD_RD, addr_now() ^ KEY ^ 32'h8000_0000);
    send(BCG_CMD_IDLE, 32'd200);
    for (int k = 0; k < 17; k++)
      send(BCG_CMD_WR, $urandom());
    chk("busy", 32'h1, {31'h0, saw_busy});
    drain();
    chk("rerr", 32'h1, {31'h0, read_error});
    chk("idle bus", 32'h0, {31'h0, bus_req});
    tally_and_finish();
  end
endmodule // bcg_bus_transactor_tb
`default_nettype wire
